//--- rtl/alo_lvds_out.sv
// Top of the sample serializer: registers, clock detect, offset and lanes
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module alo_lvds_out #(
  parameter int NUM_CH = alo_pkg::NUM_CH,
  parameter int SW = alo_pkg::SAMPLE_W,
  parameter int OW = alo_pkg::OFFSET_W
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [alo_pkg::ADDR_W-1:0] regAddr,
  input wire logic [alo_pkg::DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [alo_pkg::DATA_W-1:0] regRdData,
  input wire logic sysClockPos,
  input wire logic sysClockNeg,
  input wire logic [NUM_CH*SW-1:0] adcWords,
  input wire logic [NUM_CH*SW-1:0] autoOffsetWords,
  output logic bitClockOut,
  output logic frameClockOut,
  output logic [NUM_CH-1:0] dataLane,
  output logic [NUM_CH-1:0] laneActive,
  output logic adcPowerDown,
  output logic clockBufferEnable
);
  localparam int OFF_REGS = 2 * NUM_CH;
  localparam int OFF_IW = $clog2(OFF_REGS);
  localparam int FW = 2 * SW;
  localparam int SE_CW = $clog2(alo_pkg::SE_DETECT_CYC + 1);
  localparam logic [SE_CW-1:0] SE_MAX = SE_CW'(alo_pkg::SE_DETECT_CYC);
  localparam int HALF = NUM_CH / 2;
  localparam int QUART = NUM_CH / 4;

  logic [15:0] rateReg;
  logic [15:0] ctrlReg;
  logic [15:0] lanePdReg;
  logic [OW-1:0] offReg [OFF_REGS];
  logic [15:0] rdValue;
  alo_pkg::alo_cfg_s cfg;

  logic posSync1;
  logic posSync2;
  logic posSync3;
  logic negSync1;
  logic negSync2;
  logic [SE_CW-1:0] seCntReg;
  logic [SE_CW-1:0] seCntNext;
  logic singleEndedReg;

  logic [2:0] phaseReg;
  logic [2:0] phaseNext;
  logic [5:0] bitIdxReg;
  logic [5:0] bitIdxNext;
  logic [2:0] bitCyc;
  logic [5:0] wordBits;
  logic [5:0] frameBits;
  logic bitEnd;
  logic frameEnd;
  logic bitClkNext;
  logic frameClkNext;
  logic sampleStrobe;

  logic [SW-1:0] chanWord [NUM_CH];

  // Configuration view, one driver, fields in struct order
  assign cfg = {
    rateReg[alo_pkg::RATE_2X_BIT],
    ctrlReg[alo_pkg::CTRL_RES12_BIT],
    ctrlReg[alo_pkg::CTRL_OFFEN_BIT],
    ctrlReg[alo_pkg::CTRL_OFFSEL_BIT],
    ctrlReg[alo_pkg::CTRL_CW_BIT]
  };

  // Register decode
  wire logic hitRate = regAddr == alo_pkg::REG_RATE;
  wire logic hitCtrl = regAddr == alo_pkg::REG_CTRL;
  wire logic hitPd = regAddr == alo_pkg::REG_LANE_PD;
  wire logic hitStat = regAddr == alo_pkg::REG_STATUS;
  wire logic hitOff = (regAddr >= alo_pkg::REG_OFF_FIRST) &&
                      (regAddr <= alo_pkg::REG_OFF_LAST);
  wire logic [7:0] offDelta = regAddr - alo_pkg::REG_OFF_FIRST;
  wire logic [OFF_IW-1:0] offIdx = offDelta[OFF_IW-1:0];
  wire logic [15:0] statusWord = {14'h0000, cfg.cwMode, singleEndedReg};

  assign rdValue = hitRate ? rateReg :
                   hitCtrl ? ctrlReg :
                   hitPd ? lanePdReg :
                   hitStat ? statusWord :
                   hitOff ? 16'(offReg[offIdx]) : 16'h0000;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rateReg <= alo_pkg::RATE_RST;
      ctrlReg <= alo_pkg::CTRL_RST;
      lanePdReg <= alo_pkg::LANE_PD_RST;
    end else if (regWr) begin
      if (hitRate) begin
        rateReg <= regWrData;
      end
      if (hitCtrl) begin
        ctrlReg <= regWrData;
      end
      if (hitPd) begin
        lanePdReg <= regWrData;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < OFF_REGS; i++) begin
        offReg[i] <= '0;
      end
    end else if (regWr && hitOff) begin
      offReg[offIdx] <= regWrData[OW-1:0];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRd ? rdValue : 16'h0000;
    end
  end

  // Pin synchronisers; first stages feed only second stages
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      posSync1 <= 1'b0;
      posSync2 <= 1'b0;
      posSync3 <= 1'b0;
      negSync1 <= 1'b1;
      negSync2 <= 1'b1;
    end else begin
      posSync1 <= sysClockPos;
      posSync2 <= posSync1;
      posSync3 <= posSync2;
      negSync1 <= sysClockNeg;
      negSync2 <= negSync1;
    end
  end

  assign sampleStrobe = posSync2 & ~posSync3;

  assign seCntNext = negSync2 ? '0 : ((seCntReg == SE_MAX) ? SE_MAX : SE_CW'(seCntReg + 1'b1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seCntReg <= '0;
      singleEndedReg <= 1'b0;
      clockBufferEnable <= 1'b1;
    end else begin
      seCntReg <= seCntNext;
      singleEndedReg <= seCntNext == SE_MAX;
      clockBufferEnable <= seCntNext != SE_MAX;
    end
  end

  // Offset subtraction per channel
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
      alo_offset_sat #(
        .SW(SW),
        .OW(OW)
      ) u_off (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .load(sampleStrobe & ~cfg.cwMode),
        .subEnable(cfg.offsetSubEnable),
        .useManual(cfg.offsetSourceSelect),
        .sample(adcWords[c*SW +: SW]),
        .manualOffset(offReg[2*c]),
        .autoOffset(autoOffsetWords[c*SW +: SW]),
        .result(chanWord[c])
      );
    end
  endgenerate

  assign wordBits = cfg.res12 ? 6'(alo_pkg::LOW_RES_W) : 6'(SW);
  // bit period halves at double rate
  assign bitCyc = cfg.doubleRate ? alo_pkg::BIT_CYC_2X : alo_pkg::BIT_CYC_1X;
  // one or two words per frame
  assign frameBits = cfg.doubleRate ? 6'(wordBits << 1) : wordBits;
  assign bitEnd = phaseReg >= bitCyc - 3'h1;
  assign frameEnd = bitEnd && (bitIdxReg >= frameBits - 6'h01);
  assign phaseNext = bitEnd ? 3'h0 : phaseReg + 3'h1;
  assign bitIdxNext = frameEnd ? 6'h00 : (bitEnd ? bitIdxReg + 6'h01 : bitIdxReg);
  assign bitClkNext = phaseNext < (bitCyc >> 1);
  // frame high over even channel word at double rate, first half word at single rate
  assign frameClkNext = cfg.doubleRate ? (bitIdxNext < wordBits) :
                        (bitIdxNext < (wordBits >> 1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseReg <= 3'h0;
      bitIdxReg <= 6'h00;
      bitClockOut <= 1'b0;
      frameClockOut <= 1'b0;
    end else begin
      phaseReg <= phaseNext;
      bitIdxReg <= bitIdxNext;
      bitClockOut <= bitClkNext;
      frameClockOut <= frameClkNext;
    end
  end

  // lanes powered unless own bit set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      laneActive <= '1;
      adcPowerDown <= 1'b0;
    end else begin
      laneActive <= ~lanePdReg[NUM_CH-1:0];
      adcPowerDown <= cfg.cwMode;
    end
  end

  generate
    for (genvar l = 0; l < NUM_CH; l++) begin : g_lane
      localparam int PAIR = (l / HALF) * HALF + 2 * (l % HALF);
      localparam bit USED = (l % HALF) < QUART;
      logic [SW-1:0] firstWord;
      logic [SW-1:0] secondWord;
      logic [FW-1:0] frameWord;

      // one channel per lane at single rate
      // pair mapping, idle lanes send zero
      if (USED) begin : g_used
        assign firstWord = cfg.doubleRate ? chanWord[PAIR] : chanWord[l];
        assign secondWord = cfg.doubleRate ? chanWord[PAIR+1] : '0;
      end else begin : g_idle
        assign firstWord = cfg.doubleRate ? '0 : chanWord[l];
        assign secondWord = '0;
      end
      // Low resolution drops the two LSBs of the channel word
      assign frameWord = cfg.res12 ?
                         {firstWord[SW-1:2], secondWord[SW-1:2], 4'h0} :
                         {firstWord, secondWord};

      alo_lane_ser #(
        .FW(FW)
      ) u_ser (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .load(frameEnd),
        .shift(bitEnd & ~frameEnd),
        .powerDown(lanePdReg[l]),
        .frameWord(frameWord),
        .laneBit(dataLane[l])
      );
    end
  endgenerate
endmodule
`default_nettype wire

//--- include/alo_pkg.sv
// Constants, register map and types for the LVDS sample output block
package alo_pkg;
  localparam int NUM_CH = 16;
  localparam int SAMPLE_W = 14;
  localparam int LOW_RES_W = 12;
  localparam int OFFSET_W = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] REG_RATE = 8'h01;
  localparam logic [7:0] REG_OFF_FIRST = 8'h0d;
  localparam logic [7:0] REG_OFF_LAST = 8'h2c;
  localparam logic [7:0] REG_CTRL = 8'h40;
  localparam logic [7:0] REG_LANE_PD = 8'h41;
  localparam logic [7:0] REG_STATUS = 8'h42;

  localparam int RATE_2X_BIT = 14;
  localparam int CTRL_RES12_BIT = 0;
  localparam int CTRL_OFFEN_BIT = 1;
  localparam int CTRL_OFFSEL_BIT = 2;
  localparam int CTRL_CW_BIT = 3;

  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] LANE_PD_RST = 16'h0000;

  localparam logic [2:0] BIT_CYC_1X = 3'h4;
  localparam logic [2:0] BIT_CYC_2X = 3'h2;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SE_DETECT_NS = 1000;
  localparam int SE_DETECT_CYC = (SE_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic doubleRate;
    logic res12;
    logic offsetSubEnable;
    logic offsetSourceSelect;
    logic cwMode;
  } alo_cfg_s;
endpackage

//--- rtl/alo_offset_sat.sv
// One channel of offset subtraction with saturation
`timescale 1ns/1ps
`default_nettype none
module alo_offset_sat #(
  parameter int SW = 14,
  parameter int OW = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic subEnable,
  input wire logic useManual,
  input wire logic [SW-1:0] sample,
  input wire logic [OW-1:0] manualOffset,
  input wire logic [SW-1:0] autoOffset,
  output logic [SW-1:0] result
);
  logic signed [SW:0] offExt;
  logic signed [SW:0] diff;
  logic [SW-1:0] satVal;
  logic [SW-1:0] resultNext;

  assign offExt = useManual ? (SW+1)'($signed(manualOffset)) : (SW+1)'($signed(autoOffset));
  assign diff = (SW+1)'($signed(sample)) - offExt;
  assign satVal = (diff[SW] != diff[SW-1]) ?
                  {diff[SW], {(SW-1){~diff[SW]}}} : diff[SW-1:0];
  assign resultNext = subEnable ? satVal : sample;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= '0;
    end else if (load) begin
      result <= resultNext;
    end
  end
endmodule
`default_nettype wire

//--- rtl/alo_lane_ser.sv
// One LVDS data lane serializer, MSB first
`timescale 1ns/1ps
`default_nettype none
module alo_lane_ser #(
  parameter int FW = 28
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic shift,
  input wire logic powerDown,
  input wire logic [FW-1:0] frameWord,
  output logic laneBit
);
  logic [FW-1:0] shiftReg;
  logic [FW-1:0] shiftNext;

  assign shiftNext = load ? frameWord : (shift ? {shiftReg[FW-2:0], 1'b0} : shiftReg);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg <= '0;
      laneBit <= 1'b0;
    end else begin
      shiftReg <= shiftNext;
      laneBit <= shiftNext[FW-1] & ~powerDown;
    end
  end
endmodule
`default_nettype wire

//--- verif/alo_lvds_out_checker.sv
// Port assertions for the LVDS sample output block
`timescale 1ns/1ps
`default_nettype none
module alo_lvds_out_checker #(
  parameter int NUM_CH = alo_pkg::NUM_CH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  input wire logic sysClockNeg,
  input wire logic bitClockOut,
  input wire logic frameClockOut,
  input wire logic [NUM_CH-1:0] dataLane,
  input wire logic [NUM_CH-1:0] laneActive,
  input wire logic adcPowerDown,
  input wire logic clockBufferEnable
);
  // Link timing is only judged once a config write has settled
  logic [6:0] quiet;
  logic [8:0] negRun, frRun;
  logic [15:0] rateSh, pdSh;
  logic cwSh;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet <= 7'h00;
      negRun <= 9'h000;
      frRun <= 9'h000;
      rateSh <= alo_pkg::RATE_RST;
      pdSh <= alo_pkg::LANE_PD_RST;
      cwSh <= 1'b0;
    end else begin
      quiet <= regWr ? 7'h00 : quiet + 7'(quiet != 7'h7f);
      negRun <= sysClockNeg ? 9'h000 : negRun + 9'(negRun != 9'h1ff);
      frRun <= $changed(frameClockOut) ? 9'h001 : frRun + 9'h001;
      if (regWr && regAddr == alo_pkg::REG_RATE) rateSh <= regWrData;
      if (regWr && regAddr == alo_pkg::REG_LANE_PD) pdSh <= regWrData;
      if (regWr && regAddr == alo_pkg::REG_CTRL) cwSh <= regWrData[alo_pkg::CTRL_CW_BIT];
    end
  end
  property p_rdIdle; !$past(regRd) |-> regRdData == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_rdRate; regRd && regAddr == alo_pkg::REG_RATE |=> regRdData == rateSh; endproperty
  a_rdRate: assert property (p_rdRate) else $error("rate readback wrong");
  property p_pd; quiet == 7'h08 |-> laneActive == ~pdSh; endproperty
  a_pd: assert property (p_pd) else $error("lane power wrong");
  property p_pdZero; quiet == 7'h7f |-> (dataLane & ~laneActive) == '0; endproperty
  a_pdZero: assert property (p_pdZero) else $error("dead lane toggles");
  property p_cw; quiet == 7'h08 |-> adcPowerDown == cwSh; endproperty
  a_cw: assert property (p_cw) else $error("power down wrong");
  property p_frame;
    quiet == 7'h7f && $changed(frameClockOut) |-> frRun == 9'h018 || frRun == 9'h01c;
  endproperty
  a_frame: assert property (p_frame) else $error("frame half wrong");
  property p_bitAlign; quiet == 7'h7f && $changed(dataLane) |-> $rose(bitClockOut); endproperty
  a_bitAlign: assert property (p_bitAlign) else $error("lane off bit edge");
  property p_seDet;
    $fell(clockBufferEnable) |-> negRun >= 9'h0fa && negRun <= 9'h102;
  endproperty
  a_seDet: assert property (p_seDet) else $error("single ended timing");
  c_rate: cover property (regRd && regAddr == alo_pkg::REG_RATE);
  c_single: cover property ($fell(clockBufferEnable));
  c_cw: cover property ($rose(adcPowerDown));
endmodule
bind alo_lvds_out alo_lvds_out_checker #(.NUM_CH(NUM_CH)) i_chk (
  .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sysClockNeg(sysClockNeg),
  .bitClockOut(bitClockOut), .frameClockOut(frameClockOut), .dataLane(dataLane),
  .laneActive(laneActive), .adcPowerDown(adcPowerDown), .clockBufferEnable(clockBufferEnable)
);
`default_nettype wire

//--- verif/alo_rx_model.sv
// Receiver model that deserializes the sample lanes
`timescale 1ns/1ps
`default_nettype none
module alo_rx_model (
  input wire logic bitClk,
  input wire logic frameClk,
  input wire logic [15:0] lanes,
  output logic [27:0] rxWord [16],
  output int rxBits,
  output int rxCount
);
  logic [27:0] sh [16];
  logic frPrev = 1'b0;
  int nb = 0;
  int cnt = 0;
  assign rxCount = cnt;
  // word starts at frame rise, high phase first
  always @(negedge bitClk) begin
    if (frameClk && !frPrev) begin
      rxWord <= sh;
      rxBits <= nb;
      cnt <= cnt + 1;
      nb = 0;
    end
    frPrev = frameClk;
    nb = nb + 1;
    for (int l = 0; l < 16; l++) sh[l] = {sh[l][26:0], lanes[l]};
  end
endmodule
`default_nettype wire

//--- verif/alo_lvds_out_tb.sv
// Self-checking bench for the LVDS sample output block
`timescale 1ns/1ps
`default_nettype none
module alo_lvds_out_tb;
  logic core_clk, arst_n, regWr, regRd, sysClockPos, seMode;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, dataLane, laneActive, pdMask;
  logic [223:0] adcWords, autoOffsetWords;
  logic bitClockOut, frameClockOut, adcPowerDown, clockBufferEnable;
  logic [27:0] rxWord [16];
  logic [9:0] offs [16];
  int rxBits, rxCount, errTotal, nCompared;
  wire logic sysClockNeg = seMode ? 1'b0 : ~sysClockPos;
  alo_lvds_out i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sysClockPos(sysClockPos),
    .sysClockNeg(sysClockNeg), .adcWords(adcWords), .autoOffsetWords(autoOffsetWords),
    .bitClockOut(bitClockOut), .frameClockOut(frameClockOut), .dataLane(dataLane),
    .laneActive(laneActive), .adcPowerDown(adcPowerDown), .clockBufferEnable(clockBufferEnable)
  );
  alo_rx_model i_rx (
    .bitClk(bitClockOut), .frameClk(frameClockOut), .lanes(dataLane), .rxWord(rxWord),
    .rxBits(rxBits), .rxCount(rxCount)
  );
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    sysClockPos = 1'b0;
    #1.3;
    forever #24 sysClockPos = ~sysClockPos;
  end
  initial begin
    #60000;
    errTotal++;
    closeOut();
  end
  task automatic closeOut();
    $display("compared %0d mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    // Let an edge pass so the strobe is never driven twice in one step
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    // Data stands until this edge; taken before it clears
    @(posedge core_clk);
    chk(32'(regRdData), 32'(e));
  endtask
  task automatic waitFr(input int n);
    int s;
    s = rxCount;
    for (int i = 0; i < 800 && rxCount < s + n; i++) @(posedge core_clk);
  endtask
  function automatic logic [13:0] expW(input int c, input bit on, input bit man);
    int r;
    r = $signed(adcWords[c*14+:14]);
    if (on) r -= man ? int'($signed(offs[c])) : int'($signed(autoOffsetWords[c*14+:14]));
    r = r > 8191 ? 8191 : r < -8192 ? -8192 : r;
    return 14'(r);
  endfunction
  task automatic lanes(input bit on, input bit man, input bit x2, input bit r12);
    logic [27:0] e;
    int c;
    waitFr(3);
    chk(32'(rxBits), x2 ? 32'h1c : r12 ? 32'h0c : 32'h0e);
    for (int l = 0; l < 16; l++) begin
      c = 2 * (l % 8) + 8 * (l / 8);
      e = x2 ? (l % 8 < 4 ? {expW(c, on, man), expW(c + 1, on, man)} : 28'h0)
             : 28'(expW(l, on, man) >> (r12 ? 2 : 0));
      if (pdMask[l]) e = 28'h0;
      chk(32'(rxWord[l] & (x2 ? 28'hfffffff : r12 ? 28'hfff : 28'h3fff)), 32'(e));
    end
  endtask
  initial begin
    {arst_n, regWr, regRd, seMode} = 4'h0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    pdMask = 16'h0000;
    errTotal = 0;
    nCompared = 0;
    autoOffsetWords = {16{14'h3ff9}};
    for (int c = 0; c < 16; c++) begin
      adcWords[c*14+:14] = 14'(c * 700 + 33);
      offs[c] = c[0] ? 10'h3fd : 10'h01d;
    end
    // Full-scale words so both saturation ends are hit
    adcWords[27:14] = 14'h1fff;
    adcWords[41:28] = 14'h2000;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h01, alo_pkg::RATE_RST);
    rd(8'h40, alo_pkg::CTRL_RST);
    rd(8'h41, alo_pkg::LANE_PD_RST);
    wr(8'h42, 16'hffff);
    wr(8'h80, 16'hffff);
    rd(8'h42, 16'h0000);
    rd(8'h80, 16'h0000);
    wr(8'h01, 16'h3a5a);
    rd(8'h01, 16'h3a5a);
    wr(8'h01, 16'h0000);
    lanes(0, 0, 0, 0);
    for (int c = 0; c < 16; c++) begin
      wr(8'h0d + 8'(2 * c), {6'h00, offs[c]});
      wr(8'h0e + 8'(2 * c), {6'h00, offs[c]});
    end
    rd(8'h0f, {6'h00, offs[1]});
    wr(8'h40, 16'h0006);
    lanes(1, 1, 0, 0);
    wr(8'h40, 16'h0002);
    lanes(1, 0, 0, 0);
    wr(8'h40, 16'h0003);
    lanes(1, 0, 0, 1);
    wr(8'h40, 16'h0000);
    wr(8'h01, 16'h4000);
    lanes(0, 0, 1, 0);
    chk(32'(laneActive), 32'h0000ffff);
    pdMask = 16'h00f0;
    wr(8'h41, pdMask);
    wr(8'h01, 16'h0000);
    lanes(0, 0, 0, 0);
    chk(32'(laneActive), 32'h0000ff0f);
    wr(8'h40, 16'h0008);
    waitFr(1);
    chk(32'(adcPowerDown), 32'h1);
    rd(8'h42, 16'h0002);
    seMode <= 1'b1;
    for (int i = 0; i < 400 && clockBufferEnable !== 1'b0; i++) @(posedge core_clk);
    chk(32'(clockBufferEnable), 32'h0);
    rd(8'h42, 16'h0003);
    closeOut();
  end
endmodule
`default_nettype wire
